// >>> sar_link_pkg.sv
package sar_link_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESULT_BITS   = 16;
  localparam int HEADER_BITS   = 3;
  localparam logic [2:0] HEADER_WORD = 3'h2;
  localparam int SHIFT_BITS    = RESULT_BITS + HEADER_BITS;
  localparam int ECHO_PULSES   = 16;
  localparam int SELF_PULSES   = 18;

  // Link timing, nanoseconds
  localparam int CONVERSION_PERIOD_MAX_NS = 4000;
  localparam int START_PULSE_HIGH_MAX_NS  = 40;
  localparam int MSB_READY_TIME_NS        = 300;
  localparam int READOUT_DEADLINE_NS      = 100;

  // Derived cycle counts: longest times round down, least times round up
  localparam int CONVERSION_PERIOD_MAX_CYC = CONVERSION_PERIOD_MAX_NS / CLK_PERIOD_NS;
  localparam int START_PULSE_HIGH_MAX_CYC  = START_PULSE_HIGH_MAX_NS / CLK_PERIOD_NS;
  localparam int MSB_READY_CYC             = (MSB_READY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READOUT_DEADLINE_CYC      = READOUT_DEADLINE_NS / CLK_PERIOD_NS;

  // Host clock divider: half period in system cycles (160 ns link clock)
  localparam int LINK_HALF_CYC = 8;
  localparam int SETTLE_CYC    = 2 * LINK_HALF_CYC;
  localparam int FIFO_DEPTH    = 8;
endpackage

// >>> sar_link_if.sv
`timescale 1ns/1ps
interface sar_link_if;
  logic conversion_start;
  logic host_clock;
  logic self_clocked_strap;
  logic serial_data;
  logic echoed_readout_clock;

  modport device (
    input  conversion_start,
    input  host_clock,
    input  self_clocked_strap,
    output serial_data,
    output echoed_readout_clock
  );

  modport host (
    output conversion_start,
    output host_clock,
    output self_clocked_strap,
    input  serial_data,
    input  echoed_readout_clock
  );
endinterface

// >>> result_fifo.sv
`timescale 1ns/1ps
module result_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clock,
  input  wire logic             i_reset_n,
  input  wire logic [WIDTH-1:0] i_in_data,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  output logic [WIDTH-1:0]      o_out_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("result_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign o_in_ready  = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data  = mem[rd_ptr];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// >>> sar_device_end.sv
`timescale 1ns/1ps
module sar_device_end #(
  parameter int MSB_CYC      = sar_link_pkg::MSB_READY_CYC,
  parameter int DEADLINE_CYC = sar_link_pkg::READOUT_DEADLINE_CYC
) (
  input  wire logic                           i_clock,
  input  wire logic                           i_reset_n,
  sar_link_if.device                          link,
  input  wire logic [sar_link_pkg::RESULT_BITS-1:0] i_sample,
  output logic                                o_converting
);
  import sar_link_pkg::*;

  if (DEADLINE_CYC < 1 || DEADLINE_CYC >= MSB_CYC) begin : g_bad_timing
    $error("sar_device_end needs 1 <= DEADLINE_CYC < MSB_CYC");
  end

  localparam int CW = $clog2(MSB_CYC + 1);

  logic cnv_meta, cnv_sync, cnv_last;
  logic clk_meta, clk_sync, clk_last;
  logic mode_meta, self_mode;
  logic cnv_rise, clk_fall, load;
  logic converting, window, first_done;
  logic [CW-1:0] conv_cnt;
  logic [RESULT_BITS-1:0] captured;
  logic [RESULT_BITS-1:0] result;
  logic [SHIFT_BITS-1:0]  shifter;
  logic echo;

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      cnv_meta  <= 1'b0;
      cnv_sync  <= 1'b0;
      cnv_last  <= 1'b0;
      clk_meta  <= 1'b0;
      clk_sync  <= 1'b0;
      clk_last  <= 1'b0;
      mode_meta <= 1'b0;
      self_mode <= 1'b0;
    end else begin
      cnv_meta  <= link.conversion_start;
      cnv_sync  <= cnv_meta;
      cnv_last  <= cnv_sync;
      clk_meta  <= link.host_clock;
      clk_sync  <= clk_meta;
      clk_last  <= clk_sync;
      mode_meta <= link.self_clocked_strap;
      self_mode <= mode_meta;
    end
  end

  assign cnv_rise = cnv_sync && !cnv_last;
  assign clk_fall = clk_last && !clk_sync;
  assign load     = converting && (conv_cnt == CW'(MSB_CYC - 1));
  assign result   = first_done ? captured : '0;

  // Conversion runs a fixed time; starts seen meanwhile are dropped
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      converting <= 1'b0;
      conv_cnt   <= '0;
    end else if (cnv_rise && !converting) begin
      converting <= 1'b1;
      conv_cnt   <= '0;
    end else if (converting) begin
      if (load) begin
        converting <= 1'b0;
      end else begin
        conv_cnt <= conv_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      captured <= '0;
    end else if (cnv_rise && !converting) begin
      captured <= i_sample;
    end
  end

  // The first conversion after reset returns a fixed, meaningless word
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      first_done <= 1'b0;
    end else if (load) begin
      first_done <= 1'b1;
    end
  end

  // Readout window closes at the deadline and reopens when the MSB is ready
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      window <= 1'b0;
    end else if (converting && conv_cnt == CW'(DEADLINE_CYC - 1)) begin
      window <= 1'b0;
    end else if (load) begin
      window <= 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      shifter <= '0;
    end else if (converting && conv_cnt == CW'(DEADLINE_CYC - 1)) begin
      shifter <= '0;
    end else if (load) begin
      if (self_mode) begin
        shifter <= {HEADER_WORD, result};
      end else begin
        shifter <= {result, {HEADER_BITS{1'b0}}};
      end
    end else if (window && clk_fall) begin
      shifter <= {shifter[SHIFT_BITS-2:0], 1'b0};
    end
  end

  // Echo follows the sampled host clock in the same cycle the data shifts
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      echo <= 1'b0;
    end else begin
      echo <= window && !self_mode && clk_sync;
    end
  end

  assign link.serial_data          = shifter[SHIFT_BITS-1];
  assign link.echoed_readout_clock = echo;
  assign o_converting              = converting;
endmodule

// >>> sar_host_end.sv
`timescale 1ns/1ps
module sar_host_end #(
  parameter int PERIOD_CYC = sar_link_pkg::CONVERSION_PERIOD_MAX_CYC,
  parameter int HALF_CYC   = sar_link_pkg::LINK_HALF_CYC,
  parameter int DEPTH      = sar_link_pkg::FIFO_DEPTH
) (
  input  wire logic                           i_clock,
  input  wire logic                           i_reset_n,
  sar_link_if.host                            link,
  input  wire logic                           i_enable,
  input  wire logic                           i_self_clocked,
  output logic [sar_link_pkg::RESULT_BITS-1:0] o_result,
  output logic                                o_result_valid,
  input  wire logic                           i_result_ready,
  output logic                                o_discarded
);
  import sar_link_pkg::*;

  localparam int BURST_CYC = 2 * SELF_PULSES * HALF_CYC;
  localparam int TW = 16;

  if (PERIOD_CYC > CONVERSION_PERIOD_MAX_CYC ||
      PERIOD_CYC < MSB_READY_CYC + BURST_CYC + SETTLE_CYC + 4 ||
      HALF_CYC < 3 || HALF_CYC > 16) begin : g_bad_timing
    $error("sar_host_end timing parameters cannot be served");
  end

  typedef enum logic [5:0] {
    H_IDLE  = 6'h01,
    H_START = 6'h02,
    H_WAIT  = 6'h04,
    H_BURST = 6'h08,
    H_TAIL  = 6'h10,
    H_DONE  = 6'h20
  } host_state_t;

  function automatic logic [4:0] phase_offset(input int p);
    phase_offset = 5'((p * 2 * HALF_CYC) / 3);
  endfunction
  function automatic logic header_ok(input logic [SELF_PULSES-1:0] s);
    header_ok = (s[SELF_PULSES-1 -: 2] == HEADER_WORD[1:0]);
  endfunction

  host_state_t state;
  logic [TW-1:0] since_start;
  logic [TW-1:0] step;
  logic [4:0]    div;
  logic [5:0]    toggles;
  logic [4:0]    phase_cnt;
  logic          phase_run;
  logic          self_mode, cnv, link_clk, word_bad;
  logic          echo_meta, echo_sync, echo_last;
  logic          data_meta, data_sync;
  logic          toggle_now, rise_now, echo_rise;
  logic [5:0]    last_toggle;
  logic [SELF_PULSES-1:0] cap [3];
  logic [1:0]    pick;
  logic          found;
  logic [RESULT_BITS-1:0] word;
  logic          push;
  logic [RESULT_BITS-1:0] fifo_data;
  logic          fifo_in_ready, fifo_valid, fifo_take;

  assign toggle_now  = (state == H_BURST) && (div == 5'(HALF_CYC - 1));
  assign rise_now    = toggle_now && !link_clk;
  assign echo_rise   = echo_sync && !echo_last;
  assign last_toggle = self_mode ? 6'(2 * SELF_PULSES - 1) : 6'(2 * ECHO_PULSES - 1);

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      echo_meta <= 1'b0;
      echo_sync <= 1'b0;
      echo_last <= 1'b0;
      data_meta <= 1'b0;
      data_sync <= 1'b0;
    end else begin
      echo_meta <= link.echoed_readout_clock;
      echo_sync <= echo_meta;
      echo_last <= echo_sync;
      data_meta <= link.serial_data;
      data_sync <= data_meta;
    end
  end

  // Saturates at the maximum period; reset value marks the first word bad
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      since_start <= TW'(CONVERSION_PERIOD_MAX_CYC);
    end else if (state == H_START && step == '0) begin
      since_start <= TW'(1);
    end else if (since_start != TW'(CONVERSION_PERIOD_MAX_CYC)) begin
      since_start <= since_start + 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      state    <= H_IDLE;
      step     <= '0;
      cnv      <= 1'b0;
      word_bad <= 1'b0;
    end else begin
      unique case (state)
        H_IDLE: begin
          if (i_enable && fifo_in_ready && since_start >= TW'(PERIOD_CYC - 1)) begin
            state    <= H_START;
            step     <= '0;
            cnv      <= 1'b1;
            word_bad <= (since_start == TW'(CONVERSION_PERIOD_MAX_CYC));
          end
        end
        H_START: begin
          step <= step + 1'b1;
          if (step == TW'(START_PULSE_HIGH_MAX_CYC - 1)) begin
            cnv   <= 1'b0;
            state <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (since_start >= TW'(MSB_READY_CYC)) begin
            state <= H_BURST;
          end
        end
        H_BURST: begin
          step <= '0;
          if (toggle_now && toggles == last_toggle) begin
            state <= H_TAIL;
          end
        end
        H_TAIL: begin
          step <= step + 1'b1;
          if (step == TW'(SETTLE_CYC - 1)) begin
            state <= H_DONE;
          end
        end
        H_DONE: begin
          state <= H_IDLE;
        end
      endcase
    end
  end

  // Mode only changes between conversions
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      self_mode <= 1'b0;
    end else if (state == H_IDLE) begin
      self_mode <= i_self_clocked;
    end
  end

  // Clock divider: bursts of pulses, parked at the mode's idle level
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      link_clk <= 1'b0;
      div      <= '0;
      toggles  <= '0;
    end else if (state != H_BURST) begin
      link_clk <= (state == H_IDLE) ? i_self_clocked : self_mode;
      div      <= '0;
      toggles  <= '0;
    end else if (toggle_now) begin
      link_clk <= !link_clk;
      div      <= '0;
      toggles  <= toggles + 1'b1;
    end else begin
      div <= div + 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      phase_run <= 1'b0;
      phase_cnt <= '0;
    end else if (rise_now) begin
      phase_run <= 1'b1;
      phase_cnt <= '0;
    end else if (phase_run) begin
      if (phase_cnt == 5'(2 * HALF_CYC - 1)) begin
        phase_run <= 1'b0;
      end else begin
        phase_cnt <= phase_cnt + 1'b1;
      end
    end
  end

  for (genvar p = 0; p < 3; p++) begin : g_phase
    always_ff @(posedge i_clock) begin
      if (!i_reset_n || state == H_START) begin
        cap[p] <= '0;
      end else if (self_mode && phase_run && phase_cnt == phase_offset(p)) begin
        cap[p] <= {cap[p][SELF_PULSES-2:0], data_sync};
      end else if (p == 0 && !self_mode && echo_rise &&
                   (state == H_BURST || state == H_TAIL)) begin
        cap[p] <= {cap[p][SELF_PULSES-2:0], data_sync};
      end
    end
  end

  // Prefer the middle phase, then the late one, then the early one
  always_comb begin
    found = 1'b0;
    pick  = 2'd0;
    for (int i = 0; i < 3; i++) begin
      if (!found && header_ok(cap[(i + 1) % 3])) begin
        found = 1'b1;
        pick  = 2'((i + 1) % 3);
      end
    end
  end

  assign word = self_mode ? cap[pick][RESULT_BITS-1:0] : cap[0][RESULT_BITS-1:0];
  assign push = (state == H_DONE) && !word_bad && (found || !self_mode);
  result_fifo #(.WIDTH(RESULT_BITS), .DEPTH(DEPTH)) u_fifo (
    .i_clock     (i_clock),
    .i_reset_n   (i_reset_n),
    .i_in_data   (word),
    .i_in_valid  (push),
    .o_in_ready  (fifo_in_ready),
    .o_out_data  (fifo_data),
    .o_out_valid (fifo_valid),
    .i_out_ready (fifo_take)
  );
  assign fifo_take = !o_result_valid || i_result_ready;

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_result_valid <= 1'b0;
      o_result       <= '0;
    end else if (fifo_take) begin
      o_result_valid <= fifo_valid;
      o_result       <= fifo_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_discarded <= 1'b0;
    end else begin
      o_discarded <= (state == H_DONE) && !push;
    end
  end

  assign link.conversion_start   = cnv;
  assign link.host_clock         = link_clk;
  assign link.self_clocked_strap = self_mode;
endmodule

// >>> sar_link_asserts.sv
`timescale 1ns/1ps
module sar_link_asserts
  import sar_link_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic conversion_start,
  input wire logic host_clock,
  input wire logic self_clocked_strap,
  input wire logic serial_data,
  input wire logic echoed_readout_clock
);
  import sar_link_pkg::*;
  localparam int HI_MAX = START_PULSE_HIGH_MAX_CYC;
  logic [9:0] cyc;
  logic [4:0] falls;

  // Cycles and host clock falls since the latest start
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      cyc <= 10'h3ff;
      falls <= 5'h0;
    end else if ($rose(conversion_start)) begin
      cyc <= 10'h0;
      falls <= 5'h0;
    end else begin
      if (cyc != 10'h3ff)
        cyc <= cyc + 10'h1;
      if ($fell(host_clock))
        falls <= falls + 5'h1;
    end
  end

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);

  sequence s_quiet;
    $stable(host_clock) [*8];
  endsequence
  sequence s_blank;
    (!serial_data && !echoed_readout_clock) [*8];
  endsequence

  property p_start_low;
    $rose(conversion_start) |-> ##[1:HI_MAX] !conversion_start;
  endproperty
  property p_burst_gate;
    $rose(conversion_start) |-> s_quiet ##1 s_quiet ##1 s_quiet;
  endproperty
  property p_idle_low;
    !self_clocked_strap && $rose(conversion_start) |-> !host_clock [*8];
  endproperty
  property p_idle_high;
    self_clocked_strap && $rose(conversion_start) |-> host_clock [*8];
  endproperty
  property p_blank;
    !self_clocked_strap && $rose(conversion_start) |-> ##14 s_blank;
  endproperty
  property p_header;
    self_clocked_strap && $rose(conversion_start) |-> ##33 !serial_data [*4];
  endproperty
  property p_echo_rise;
    $rose(echoed_readout_clock) |-> host_clock && !self_clocked_strap;
  endproperty
  property p_echo_fall;
    $fell(echoed_readout_clock) |-> !host_clock;
  endproperty
  property p_data_on_fall;
    !self_clocked_strap && $changed(serial_data) |-> !echoed_readout_clock;
  endproperty
  property p_self_echo;
    $past(self_clocked_strap, 4) && self_clocked_strap |-> !echoed_readout_clock;
  endproperty
  property p_pulses;
    cyc == 10'd340 |-> falls == (self_clocked_strap ? SELF_PULSES : ECHO_PULSES);
  endproperty

  a_start_low: assert property (p_start_low)
    else $error("start pulse held high too long");
  a_burst_gate: assert property (p_burst_gate)
    else $error("host clock moved before data ready");
  a_idle_low: assert property (p_idle_low)
    else $error("echoed mode clock not parked low");
  a_idle_high: assert property (p_idle_high)
    else $error("self clocked mode clock not parked high");
  a_blank: assert property (p_blank)
    else $error("data or echo not held low while blanked");
  a_header: assert property (p_header)
    else $error("leading header zero missing");
  a_echo_rise: assert property (p_echo_rise)
    else $error("echo rose without host clock high");
  a_echo_fall: assert property (p_echo_fall)
    else $error("echo fell without host clock low");
  a_data_on_fall: assert property (p_data_on_fall)
    else $error("data changed while echo high");
  a_self_echo: assert property (p_self_echo)
    else $error("echo active in self clocked mode");
  a_pulses: assert property (p_pulses)
    else $error("wrong pulse count in burst");
endmodule

// >>> sar_adc_lvds_readout_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin \
  checks++; \
  if ((a) !== (e)) begin \
    errors++; \
    $display("ERROR %0t got %h exp %h", $time, (a), (e)); \
  end \
end
module sar_adc_lvds_readout_tb_top;
  import sar_link_pkg::*;
  localparam int P = CONVERSION_PERIOD_MAX_CYC;
  sar_link_if i_sar_link_if ();
  logic        i_clock = 1'b0;
  logic        i_reset_n = 1'b0;
  logic [15:0] i_sample = 16'h0;
  logic        i_enable = 1'b0;
  logic        i_self_clocked = 1'b0;
  logic        i_result_ready = 1'b0;
  logic        o_converting;
  logic [15:0] o_result;
  logic        o_result_valid;
  logic        o_discarded;
  int          errors = 0;
  int          checks = 0;
  int          gap = 0;
  int          nbits = 0;
  int          n_conv = 0;
  int          disc_exp = 0;
  int          disc_seen = 0;
  int          rdy_mode = 1;
  bit          fresh = 1'b1;
  bit          bad;
  logic        conv_q = 1'b0;
  logic        conv_n = 1'b0;
  logic        strobe_q = 1'b0;
  logic [17:0] shreg = 18'h0;
  logic [17:0] w;
  logic [17:0] mask;
  logic [15:0] e16;
  logic [15:0] exp_q[$];
  bit          bad_q[$];
  logic [17:0] wire_q[$];
  logic [15:0] corner_q[$];
  wire         strap = i_sar_link_if.self_clocked_strap;
  wire         strobe = strap ? i_sar_link_if.host_clock : i_sar_link_if.echoed_readout_clock;

  sar_device_end i_sar_device_end (.i_clock(i_clock), .i_reset_n(i_reset_n), .link(i_sar_link_if),
    .i_sample(i_sample), .o_converting(o_converting));
  sar_host_end #(.PERIOD_CYC(P)) i_sar_host_end (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .link(i_sar_link_if), .i_enable(i_enable), .i_self_clocked(i_self_clocked), .o_result(o_result),
    .o_result_valid(o_result_valid), .i_result_ready(i_result_ready), .o_discarded(o_discarded));
  sar_link_asserts i_sar_link_asserts (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .conversion_start(i_sar_link_if.conversion_start), .host_clock(i_sar_link_if.host_clock),
    .self_clocked_strap(i_sar_link_if.self_clocked_strap), .serial_data(i_sar_link_if.serial_data),
    .echoed_readout_clock(i_sar_link_if.echoed_readout_clock));

  always #(CLK_PERIOD_NS / 2) i_clock = ~i_clock;

  // Word on the wire: header then the sample, zero for the first after reset
  function automatic logic [17:0] wire_word(input bit first, input logic [15:0] s);
    return {HEADER_WORD[1:0], first ? 16'h0 : s};
  endfunction

  // Expected words queue up as each conversion starts
  always @(posedge i_clock) begin
    gap++;
    if (o_converting === 1'b1 && conv_q === 1'b0) begin
      bad = fresh || gap > P;
      exp_q.push_back(i_sample);
      bad_q.push_back(bad);
      disc_exp += bad;
      wire_q.push_back(wire_word(fresh, i_sample));
      fresh = 1'b0;
      gap = 0;
      nbits = 0;
      n_conv++;
    end
    conv_q = o_converting;
    if (strobe === 1'b1 && strobe_q === 1'b0) begin
      shreg = {shreg[16:0], i_sar_link_if.serial_data};
      nbits++;
      mask = strap ? 18'h3ffff : 18'h0ffff;
      if (nbits == (strap ? SELF_PULSES : ECHO_PULSES)) begin
        w = wire_q.pop_front();
        `CHK(shreg & mask, w & mask)
      end
    end
    strobe_q = strobe;
    if (o_result_valid === 1'b1 && i_result_ready === 1'b1) begin
      while (bad_q.size() > 0 && bad_q[0]) begin
        void'(exp_q.pop_front());
        void'(bad_q.pop_front());
      end
      void'(bad_q.pop_front());
      e16 = exp_q.pop_front();
      `CHK(o_result, e16)
    end
    if (o_discarded === 1'b1)
      disc_seen++;
  end

  // New sample once the previous conversion has taken its copy
  always @(negedge i_clock) begin
    i_result_ready <= rdy_mode == 2 ? 1'($urandom_range(1)) : rdy_mode[0];
    if (o_converting === 1'b0 && conv_n === 1'b1)
      i_sample <= corner_q.size() > 0 ? corner_q.pop_front() : 16'($urandom());
    conv_n <= o_converting;
  end

  task automatic run(input int n);
    repeat (n) @(negedge i_clock);
  endtask

  task automatic reset_dut();
    i_reset_n = 1'b0;
    run(12);
    exp_q.delete();
    bad_q.delete();
    wire_q.delete();
    fresh = 1'b1;
    disc_exp = 0;
    disc_seen = 0;
    i_reset_n = 1'b1;
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic end_test(input string name);
    int c;
    i_enable = 1'b0;
    rdy_mode = 1;
    run(1200);
    while (bad_q.size() > 0 && bad_q[0]) begin
      void'(bad_q.pop_front());
      void'(exp_q.pop_front());
    end
    c = n_conv;
    run(P);
    `CHK(n_conv, c)
    `CHK(exp_q.size(), 0)
    `CHK(disc_seen, disc_exp)
    `CHK(o_result_valid, 1'b0)
    $display("test %s done", name);
  endtask

  initial begin
    int c0;
    void'($urandom(55548));
    reset_dut();
    i_enable = 1'b1;
    run(8 * P);
    end_test("echoed");
    i_self_clocked = 1'b1;
    run(100);
    corner_q = '{16'h0000, 16'hffff, 16'h8000, 16'h0001, 16'h5555};
    rdy_mode = 2;
    i_enable = 1'b1;
    run(10 * P);
    end_test("self_clocked");
    i_self_clocked = 1'b0;
    run(100);
    rdy_mode = 0;
    i_enable = 1'b1;
    run(14 * P);
    c0 = n_conv;
    run(5 * P);
    `CHK(n_conv, c0)
    rdy_mode = 2;
    run(10 * P);
    end_test("stall");
    rdy_mode = 2;
    i_enable = 1'b1;
    run(1000);
    reset_dut();
    run(4 * P);
    end_test("reset");
    final_report();
  end

  initial begin
    #(40000 * CLK_PERIOD_NS);
    errors++;
    final_report();
  end
endmodule
